// ### core/arsr_pkg.sv
package arsr_pkg;
    localparam int unsigned ARSR_ADDR_W = 12;
    localparam logic [9:0] ARSR_IDX_POS_B0 = 10'h02c;
    localparam logic [9:0] ARSR_IDX_POS_B1 = 10'h02d;
    localparam logic [9:0] ARSR_IDX_POS_B2 = 10'h02e;
    localparam logic [9:0] ARSR_IDX_FSA_B0 = 10'h030;
    localparam logic [9:0] ARSR_IDX_FSA_B1 = 10'h031;
    localparam logic [9:0] ARSR_IDX_FSB_B0 = 10'h032;
    localparam logic [9:0] ARSR_IDX_FSB_B1 = 10'h033;
    localparam logic [9:0] ARSR_IDX_BYPASS = 10'h038;
    localparam int unsigned ARSR_POS_W = 24;
    localparam int unsigned ARSR_FS_W = 16;
    localparam logic [23:0] ARSR_POS_RESET = 24'h000000;
    localparam logic [15:0] ARSR_FS_RESET = 16'ha000;
    localparam logic [7:0] ARSR_BYPASS_RESET = 8'h00;
    localparam int unsigned ARSR_BYPASS_BIT = 0;
endpackage

// ### core/arsr_cap_if.sv
`timescale 1ns/10ps
`default_nettype none
interface arsr_cap_if;
    logic [23:0] position;
    logic captured;
    modport cap (output position, output captured);
    modport regs (input position, input captured);
endinterface
`default_nettype wire

// ### core/arsr_capture.sv
`timescale 1ns/10ps
`default_nettype none
module arsr_capture
    import arsr_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic sysref_in,
    arsr_cap_if.cap cap
);
    logic sync1_r;
    logic sync2_r;
    logic prev_r;
    logic [ARSR_POS_W-1:0] hist_r;
    logic [ARSR_POS_W-1:0] pos_r;
    logic captured_r;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= sysref_in;
            sync2_r <= sync1_r;
        end
    end

    // The window holds the last samples so software sees where the edge fell.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            prev_r <= 1'b0;
            hist_r <= ARSR_POS_RESET;
        end else begin
            prev_r <= sync2_r;
            hist_r <= {hist_r[ARSR_POS_W-2:0], sync2_r};
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            pos_r <= ARSR_POS_RESET;
            captured_r <= 1'b0;
        end else if (sync2_r && !prev_r) begin
            pos_r <= {hist_r[ARSR_POS_W-2:0], sync2_r};
            captured_r <= 1'b1;
        end
    end

    assign cap.position = pos_r;
    assign cap.captured = captured_r;
endmodule
`default_nettype wire

// ### core/arsr_regs.sv
// The APB slave port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module arsr_regs
    import arsr_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ARSR_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sysref_in,
    output logic [15:0] full_scale_word_first_input,
    output logic [15:0] full_scale_word_second_input,
    output logic reference_bypass_bit,
    output logic sysref_position_valid
);
    arsr_cap_if cap_bus();

    logic [ARSR_FS_W-1:0] fs_a_r;
    logic [ARSR_FS_W-1:0] fs_b_r;
    logic bypass_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic valid_r;
    logic [9:0] idx;
    logic [7:0] rd_byte;
    logic hit;
    logic wr_en;

    arsr_capture u_capture (
        .core_clk(core_clk),
        .nrst(nrst),
        .sysref_in(sysref_in),
        .cap(cap_bus)
    );

    // Each byte of the map is its own word, so the byte address is four times the index.
    assign idx = paddr[ARSR_ADDR_W-1:2];

    always_comb begin
        rd_byte = 8'h00;
        hit = 1'b1;
        case (idx)
            ARSR_IDX_POS_B0: rd_byte = cap_bus.position[7:0];
            ARSR_IDX_POS_B1: rd_byte = cap_bus.position[15:8];
            ARSR_IDX_POS_B2: rd_byte = cap_bus.position[23:16];
            ARSR_IDX_FSA_B0: rd_byte = fs_a_r[7:0];
            ARSR_IDX_FSA_B1: rd_byte = fs_a_r[15:8];
            ARSR_IDX_FSB_B0: rd_byte = fs_b_r[7:0];
            ARSR_IDX_FSB_B1: rd_byte = fs_b_r[15:8];
            ARSR_IDX_BYPASS: rd_byte = {7'h00, bypass_r};
            default: hit = 1'b0;
        endcase
    end

    // One wait state keeps read data registered; the write lands on the completing edge.
    assign wr_en = psel && penable && pready_r && pwrite && hit;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end else begin
            pready_r <= psel && penable && !pready_r;
            pslverr_r <= psel && penable && !pready_r && !hit;
            if (psel && penable && !pready_r) begin
                prdata_r <= (!pwrite && hit) ? {24'h000000, rd_byte} : 32'h00000000;
            end
        end
    end

    // Writes to the position bytes are dropped: that word belongs to the capture logic.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            fs_a_r <= ARSR_FS_RESET;
            fs_b_r <= ARSR_FS_RESET;
        end else if (wr_en) begin
            case (idx)
                ARSR_IDX_FSA_B0: fs_a_r[7:0] <= pwdata[7:0];
                ARSR_IDX_FSA_B1: fs_a_r[15:8] <= pwdata[7:0];
                ARSR_IDX_FSB_B0: fs_b_r[7:0] <= pwdata[7:0];
                ARSR_IDX_FSB_B1: fs_b_r[15:8] <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            bypass_r <= ARSR_BYPASS_RESET[ARSR_BYPASS_BIT];
        end else if (wr_en && idx == ARSR_IDX_BYPASS) begin
            bypass_r <= pwdata[ARSR_BYPASS_BIT];
        end
    end

    // The code passes unchanged through one register stage; the analog range scales monotonically with it.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            full_scale_word_first_input <= ARSR_FS_RESET;
            full_scale_word_second_input <= ARSR_FS_RESET;
            reference_bypass_bit <= ARSR_BYPASS_RESET[ARSR_BYPASS_BIT];
            valid_r <= 1'b0;
        end else begin
            full_scale_word_first_input <= fs_a_r;
            full_scale_word_second_input <= fs_b_r;
            reference_bypass_bit <= bypass_r;
            valid_r <= cap_bus.captured;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign sysref_position_valid = valid_r;
endmodule
`default_nettype wire

// ### verif/arsr_regs_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module arsr_regs_monitor
    import arsr_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ARSR_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [15:0] full_scale_word_first_input,
    input wire logic [15:0] full_scale_word_second_input,
    input wire logic reference_bypass_bit
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    wire logic [9:0] idx = paddr[11:2];
    wire logic wr = pready && psel && penable && pwrite;
    one_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("no answer after one wait state");
    rdy_pulse_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    unmapped_err_a: assert property (pready && idx == 10'h034 |-> pslverr && prdata == 0)
        else $error("unmapped index not refused");
    pos_ro_a: assert property (wr && idx == ARSR_IDX_POS_B0 |-> !pslverr)
        else $error("status write flagged");
    fsa_lo_a: assert property (wr && idx == ARSR_IDX_FSA_B0 |=> ##1
        full_scale_word_first_input[7:0] == $past(pwdata[7:0], 2)) else $error("first word lo");
    fsb_hi_a: assert property (wr && idx == ARSR_IDX_FSB_B1 |=> ##1
        full_scale_word_second_input[15:8] == $past(pwdata[7:0], 2)) else $error("second word hi");
    bypass_wr_a: assert property (wr && idx == ARSR_IDX_BYPASS |=> ##1
        reference_bypass_bit == $past(pwdata[0], 2)) else $error("bypass bit");
    resv_zero_a: assert property (pready && !pwrite && idx == ARSR_IDX_BYPASS |->
        prdata[31:1] == 0) else $error("reserved bits not zero");
    reset_val_a: assert property ($rose(nrst) |-> full_scale_word_first_input == 16'ha000 &&
        full_scale_word_second_input == 16'ha000 && !reference_bypass_bit) else $error("reset");
    cov_wr_c: cover property (wr);
    cov_err_c: cover property (pready && pslverr);
    cov_byp_c: cover property (reference_bypass_bit);
endmodule
bind arsr_regs arsr_regs_monitor i_arsr_regs_monitor(.core_clk(core_clk), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .full_scale_word_first_input(full_scale_word_first_input),
    .full_scale_word_second_input(full_scale_word_second_input),
    .reference_bypass_bit(reference_bypass_bit));
`default_nettype wire

// ### verif/arsr_regs_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module arsr_regs_tb_top
    import arsr_pkg::*;
;
    logic core_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, sysref_in = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, byp, vld, er;
    logic [15:0] fsa, fsb;
    int mismatches = 0, total_checks = 0, cyc = 0;
    arsr_regs i_arsr_regs(.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sysref_in(sysref_in), .full_scale_word_first_input(fsa),
        .full_scale_word_second_input(fsb), .reference_bypass_bit(byp),
        .sysref_position_valid(vld));
    always #12.5 core_clk = ~core_clk;
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            give_verdict();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            $display("[FAIL] %s exp %h got %h", nm, e, s);
            mismatches++;
        end
    endtask
    // The master waits on pready and never assumes the one wait state.
    task automatic apb(input logic w, input logic [9:0] ix, input logic [7:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= {ix, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge core_clk);
        penable <= 1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge core_clk);
    endtask
    task automatic rdchk(input logic [9:0] ix, input logic [31:0] e);
        apb(0, ix, 8'h00);
        chk("read", e, rd);
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        nrst <= 1;
        @(posedge core_clk);
        rdchk(ARSR_IDX_FSA_B0, 32'h0);
        rdchk(ARSR_IDX_FSA_B1, 32'ha0);
        rdchk(ARSR_IDX_FSB_B1, 32'ha0);
        rdchk(ARSR_IDX_BYPASS, 32'h0);
        $display("reset values done");
        apb(1, ARSR_IDX_FSA_B0, 8'hff);
        // Calibration sits outside this block, so the codes are only checked at the ports and read back here.
        apb(1, ARSR_IDX_FSA_B1, 8'hff);
        apb(1, ARSR_IDX_FSB_B0, 8'h00);
        apb(1, ARSR_IDX_FSB_B1, 8'h20);
        apb(1, ARSR_IDX_BYPASS, 8'hff);
        @(posedge core_clk);
        chk("fsa", 32'hffff, {16'h0, fsa});
        chk("fsb", 32'h2000, {16'h0, fsb});
        chk("bypass", 32'h1, {31'h0, byp});
        rdchk(ARSR_IDX_BYPASS, 32'h1);
        rdchk(ARSR_IDX_FSA_B0, 32'hff);
        rdchk(ARSR_IDX_FSB_B0, 32'h0);
        rdchk(ARSR_IDX_FSB_B1, 32'h20);
        $display("writes done");
        apb(0, 10'h034, 8'h00);
        chk("slverr", 32'h1, {31'h0, er});
        chk("err data", 32'h0, rd);
        apb(1, ARSR_IDX_POS_B0, 8'hff);
        chk("wr no err", 32'h0, {31'h0, er});
        rdchk(ARSR_IDX_POS_B0, 32'h0);
        chk("valid idle", 32'h0, {31'h0, vld});
        sysref_in <= 1;
        repeat (8) @(posedge core_clk);
        chk("valid", 32'h1, {31'h0, vld});
        // The newest synchronised sample lands in bit 0, so a fresh edge reads as one.
        rdchk(ARSR_IDX_POS_B0, 32'h1);
        rdchk(ARSR_IDX_POS_B1, 32'h0);
        rdchk(ARSR_IDX_POS_B2, 32'h0);
        $display("status done");
        give_verdict();
    end
endmodule
`default_nettype wire
